// [dv/eedc_cpu_model.sv]
// cpu core stand-in: classic wishbone master
`default_nettype none
module eedc_cpu_model (
	input  wire logic        ref_clk, // system clock
	output logic             cyc,     // bus cycle
	output logic             stb,     // strobe
	output logic             we,      // write enable
	output logic [9:0]       adr,     // byte address
	output logic [3:0]       sel,     // byte lanes
	output logic [31:0]      dat,     // write data
	input  wire logic [31:0] rdat,    // read data
	input  wire logic        ack      // acknowledge
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{cyc, stb, we, adr, sel, dat} = '0;
	end
	// code never runs from the array, so array writes cannot spoil a fetch
	task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h1, 24'h000000, d};
		do
			@(posedge ref_clk);
		while (ack !== 1'b1);
		q = rdat;
		// released address and data lines carry junk so nothing leans on stale values; sel keeps 4'h1
		{cyc, stb, we, adr, dat} <= {3'b000, ~a, ~dat};
		@(posedge ref_clk);
	endtask : xfer
endmodule : eedc_cpu_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the data eeprom controller against a byte model
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EC = 8;
	localparam int WC = 8;
	logic        ref_clk, rst, cyc, stb, we, ack, ext_access, wfi_req, halt_req;
	logic        rd_driven, prog_busy, eeprom_wait, eeprom_halt, pmem_erase;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat, q;
	int          failures, tests_run, cycles, erase_seen, r;
	int          mem [128];
	int          lat [32];
	bit          lv [32];
	eedc_top #(.ERASE_CYCLES(EC), .WRITE_CYCLES(WC)) i_eedc_top (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ext_access(ext_access), .wfi_req(wfi_req), .halt_req(halt_req), .rd_driven(rd_driven),
		.prog_busy(prog_busy), .eeprom_wait(eeprom_wait), .eeprom_halt(eeprom_halt), .pmem_erase(pmem_erase));
	eedc_cpu_model i_eedc_cpu_model (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat(dat), .rdat(rdat), .ack(ack));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (pmem_erase === 1'b1)
			erase_seen++;
		if (cycles == 30000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input int v);
		i_eedc_cpu_model.xfer(1'b1, a, 8'(v), q);
	endtask : wr
	task automatic rd(input logic [9:0] a, input int v);
		i_eedc_cpu_model.xfer(1'b0, a, 8'h00, q);
		chk(q, 32'(v));
	endtask : rd
	function automatic logic [9:0] aa(input int i);
		return 10'h200 | 10'(i * 4);
	endfunction : aa
	task automatic latch(input int i, input int v);
		wr(aa(i), v);
		lat[i % 32] = lv[i % 32] ? (lat[i % 32] & v) : v;
		lv[i % 32] = 1'b1;
	endtask : latch
	task automatic commit(input int row);
		for (int k = 0; k < 32; k++) begin
			if (lv[k])
				mem[row * 32 + k] = lat[k];
			lv[k] = 1'b0;
		end
	endtask : commit
	task automatic finish_cycle();
		chk(32'(prog_busy), 32'h1);
		for (int k = 0; k < EC + WC && prog_busy !== 1'b0; k++)
			@(posedge ref_clk);
		chk(32'(prog_busy), 32'h0);
	endtask : finish_cycle
	task automatic check_row(input int row);
		for (int k = 0; k < 32; k++)
			rd(aa(row * 32 + k), mem[row * 32 + k]);
	endtask : check_row
	initial begin
		rst = 1'b1;
		ext_access = 1'b0;
		wfi_req = 1'b0;
		halt_req = 1'b0;
		foreach (mem[i])
			mem[i] = 255;
		void'($urandom(16));
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		r = $urandom_range(3);
		rd(10'h030, 0);
		rd(10'h06C, 0);
		rd(aa(r * 32 + 9), 255);
		wr(aa(r * 32 + 5), 0);
		wr(10'h030, 8'hFE);
		rd(10'h030, 2);
		rd(aa(r * 32), 0);
		chk(32'(rd_driven), 32'h0);
		latch(r * 32 + 7, $urandom_range(255));
		wr(10'h030, 0);
		lv = '{default: 1'b0};
		wr(10'h030, 2);
		for (int k = 0; k < 6; k++)
			latch(r * 32 + (k % 5 == 0 ? 0 : $urandom_range(31, 8)), $urandom_range(255));
		wr(10'h030, 3);
		rd(10'h030, 3);
		finish_cycle();
		commit(r);
		rd(10'h030, 0);
		check_row(r);
		wr(10'h030, 2);
		latch(99, 0);
		wr(10'h030, 3);
		halt_req <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(32'(eeprom_halt), 32'h1);
		chk(32'(prog_busy), 32'h0);
		@(posedge ref_clk);
		halt_req <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rd(10'h030, 0);
		lv = '{default: 1'b0};
		wr(10'h030, 2);
		wr(10'h030, 3);
		wr(10'h030, 2);
		chk(32'(prog_busy), 32'h0);
		rd(10'h030, 2);
		wr(10'h030, 3);
		wr(10'h030, 0);
		rd(10'h030, 2);
		wr(10'h030, 0);
		wr(10'h030, 2);
		latch(r * 32 + 1, $urandom_range(255));
		wr(10'h030, 3);
		wfi_req <= 1'b1;
		@(negedge ref_clk);
		chk(32'(eeprom_wait), 32'h0);
		finish_cycle();
		repeat (2) @(negedge ref_clk);
		chk(32'(eeprom_wait), 32'h1);
		@(posedge ref_clk);
		wfi_req <= 1'b0;
		commit(r);
		check_row(r);
		wr(eedc_pkg::OPT_OFS, 1);
		ext_access <= 1'b1;
		rd(aa(r * 32 + 1), 0);
		wr(10'h030, 2);
		wr(aa(r * 32 + 1), 0);
		wr(10'h030, 3);
		chk(32'(prog_busy), 32'h0);
		wr(10'h030, 0);
		ext_access <= 1'b0;
		rd(aa(r * 32 + 1), mem[r * 32 + 1]);
		wr(eedc_pkg::OPT_OFS, 0);
		repeat (2) @(posedge ref_clk);
		chk(erase_seen, 1);
		foreach (mem[i])
			mem[i] = 255;
		for (int k = 0; k < 128; k++)
			rd(aa(k), mem[k]);
		wr(10'h030, 2);
		wr(10'h030, 3);
		rst <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(32'(prog_busy), 32'h0);
		@(posedge ref_clk);
		rst <= 1'b0;
		rd(10'h030, 0);
		summarize();
	end
endmodule : testbench
`default_nettype wire

// [rtl/eedc_latch_if.sv]
// row latch carrier between controller and latch bank
`default_nettype none
interface eedc_latch_if;
	logic                                       wr;
	logic                                       clr;
	logic [eedc_pkg::COL_W-1:0]                 col;
	logic [7:0]                                 wdata;
	logic [eedc_pkg::ROW_BYTES-1:0]             valid;
	logic [eedc_pkg::ROW_BYTES-1:0][7:0]        data;
	modport ctrl (output wr, clr, col, wdata, input valid, data);
	modport bank (input wr, clr, col, wdata, output valid, data);
endinterface : eedc_latch_if
`default_nettype wire

// [rtl/eedc_pkg.sv]
// constants and types shared by the data eeprom controller files
`default_nettype none
package eedc_pkg;
	localparam logic [9:0] CSR_OFS      = 10'h030;
	localparam logic [9:0] OPT_OFS      = 10'h034;
	localparam int         ROW_BYTES    = 32;
	localparam int         COL_W        = 5;
	localparam int         ROW_W        = 2;
	localparam int         ARR_BYTES    = 128;
	localparam int         PGM_BIT      = 0;
	localparam int         LAT_BIT      = 1;
	localparam int         PROT_BIT     = 0;
	localparam int         ARR_SEL_BIT  = 9;
	localparam logic [7:0] CSR_RESET    = 8'h00;
	localparam logic [7:0] ERASED       = 8'hFF;
	localparam int         ERASE_CYCLES = 200;
	localparam int         WRITE_CYCLES = 200;
	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} eedc_state_t;
endpackage : eedc_pkg
`default_nettype wire

// [rtl/eedc_row_latch.sv]
// bank of 32 row latches with and-merge on rewrite
`default_nettype none
module eedc_row_latch (
	input  wire logic ref_clk,    // system clock
	input  wire logic rst,        // async reset, high
	eedc_latch_if.bank lat        // latch port
);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lat.valid <= '0;
			lat.data  <= '0;
		end else if (lat.clr) begin
			lat.valid <= '0;
			lat.data  <= '0;
		end else if (lat.wr) begin
			lat.valid[lat.col] <= 1'b1;
			// an erased cell can only lose ones, so a rewrite merges by and
			if (lat.valid[lat.col])
				lat.data[lat.col] <= lat.data[lat.col] & lat.wdata;
			else
				lat.data[lat.col] <= lat.wdata;
		end
	end

	property p_and_merge;
		@(posedge ref_clk) disable iff (rst)
		lat.wr && !lat.clr && lat.valid[lat.col] |=>
			lat.data[$past(lat.col)] == ($past(lat.data[lat.col]) & $past(lat.wdata));
	endproperty
	a_and_merge: assert property (p_and_merge) else $error("latch rewrite not and-merged");

	property p_clear;
		@(posedge ref_clk) disable iff (rst)
		lat.clr |=> lat.valid == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("latches not emptied");
endmodule : eedc_row_latch
`default_nettype wire

// [rtl/eedc_top.sv]
// data eeprom controller: wishbone slave, row latches, timed program cycle
//
// Chosen here: register access over Wishbone.
`default_nettype none
module eedc_top #(
	parameter int ERASE_CYCLES = eedc_pkg::ERASE_CYCLES,
	parameter int WRITE_CYCLES = eedc_pkg::WRITE_CYCLES
) (
	input  wire logic        ref_clk,     // system clock
	input  wire logic        rst,         // async reset, high
	input  wire logic        wb_cyc_i,    // bus cycle
	input  wire logic        wb_stb_i,    // strobe
	input  wire logic        wb_we_i,     // write enable
	input  wire logic [9:0]  wb_adr_i,    // byte address
	input  wire logic [3:0]  wb_sel_i,    // byte lanes
	input  wire logic [31:0] wb_dat_i,    // write data
	output logic      [31:0] wb_dat_o,    // read data
	output logic             wb_ack_o,    // acknowledge
	input  wire logic        ext_access,  // access made by an external tool
	input  wire logic        wfi_req,     // wait or active-halt request
	input  wire logic        halt_req,    // halt request
	output logic             rd_driven,   // eeprom drove the read data
	output logic             prog_busy,   // program cycle running
	output logic             eeprom_wait, // in wait state
	output logic             eeprom_halt, // in halt state
	output logic             pmem_erase   // program memory erase pulse
);
	localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYCLES - 1);
	localparam logic [15:0] WRITE_LAST = 16'(WRITE_CYCLES - 1);
	localparam logic [17:0] RUN_LEN    = 18'(ERASE_CYCLES + WRITE_CYCLES);

	generate
		if (ERASE_CYCLES < 1 || ERASE_CYCLES > 65536 || WRITE_CYCLES < 1 || WRITE_CYCLES > 65536)
			$error("cycle counts must lie in 1..65536");
	endgenerate

	eedc_latch_if lat_if ();

	eedc_row_latch u_latch (
		.ref_clk (ref_clk),
		.rst     (rst),
		.lat     (lat_if.bank)
	);

	eedc_pkg::eedc_state_t st;
	logic [15:0]                 cnt;
	logic                        latch_mode;
	logic                        prot;
	logic [eedc_pkg::ROW_W-1:0]  row;
	logic [7:0]                  arr [eedc_pkg::ARR_BYTES];
	logic                        next_latch_mode;

	// bus decode
	logic       req;
	logic       acc;
	logic       arr_hit;
	logic       csr_hit;
	logic       opt_hit;
	logic [6:0] idx;
	logic       csr_wr;
	logic       opt_wr;
	logic       arr_wr;
	logic       busy;
	logic       erase_done;
	logic       prog_done;
	logic       start;
	logic       sw_abort;
	logic       unprotect;
	logic       blocked;

	assign req     = wb_cyc_i && wb_stb_i;
	assign acc     = req && wb_ack_o;
	assign arr_hit = wb_adr_i[eedc_pkg::ARR_SEL_BIT];
	assign csr_hit = wb_adr_i == eedc_pkg::CSR_OFS;
	assign opt_hit = wb_adr_i == eedc_pkg::OPT_OFS;
	assign idx     = wb_adr_i[8:2];
	assign busy    = st != eedc_pkg::ST_IDLE;
	assign blocked = prot && ext_access;
	assign csr_wr  = acc && wb_we_i && wb_sel_i[0] && csr_hit;
	assign opt_wr  = acc && wb_we_i && wb_sel_i[0] && opt_hit;
	// writes land in the latches only in write mode, idle, and not blocked by protection against an external access
	assign arr_wr  = acc && wb_we_i && wb_sel_i[0] && arr_hit && latch_mode && !busy && !blocked;

	assign erase_done = st == eedc_pkg::ST_ERASE && cnt == ERASE_LAST;
	assign prog_done  = st == eedc_pkg::ST_WRITE && cnt == WRITE_LAST;
	assign start      = csr_wr && wb_dat_i[eedc_pkg::PGM_BIT] && !busy && !halt_req && !eeprom_wait
		&& (latch_mode || wb_dat_i[eedc_pkg::LAT_BIT]) && !blocked;
	assign sw_abort   = csr_wr && !wb_dat_i[eedc_pkg::PGM_BIT] && busy;
	assign unprotect  = opt_wr && prot && !wb_dat_i[eedc_pkg::PROT_BIT] && !busy && !halt_req;

	assign prog_busy = busy;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req && !wb_ack_o;
	end

	// read data is captured with the ack so it stands while ack is high
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o  <= '0;
			rd_driven <= 1'b0;
		end else if (req && !wb_ack_o && !wb_we_i) begin
			wb_dat_o  <= '0;
			rd_driven <= 1'b1;
			if (csr_hit)
				wb_dat_o[7:0] <= {6'h00, latch_mode, busy};
			else if (opt_hit)
				wb_dat_o[7:0] <= {7'h00, prot};
			else if (arr_hit) begin
				if (latch_mode)
					rd_driven <= 1'b0;
				else if (!blocked)
					wb_dat_o[7:0] <= arr[idx];
			end
		end
	end

	always_comb begin
		next_latch_mode = latch_mode;
		if (halt_req || prog_done)
			next_latch_mode = 1'b0;
		else if (csr_wr) begin
			if (wb_dat_i[eedc_pkg::LAT_BIT])
				next_latch_mode = 1'b1;
			// a write that also starts a cycle keeps write mode, so the latches survive into it
			else if (!busy && !wb_dat_i[eedc_pkg::PGM_BIT])
				next_latch_mode = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			latch_mode <= eedc_pkg::CSR_RESET[eedc_pkg::LAT_BIT];
		else
			latch_mode <= next_latch_mode;
	end

	assign lat_if.clr   = latch_mode && !next_latch_mode;
	assign lat_if.wr    = arr_wr;
	assign lat_if.col   = idx[eedc_pkg::COL_W-1:0];
	assign lat_if.wdata = wb_dat_i[7:0];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			row <= '0;
		else if (arr_wr)
			row <= idx[6:eedc_pkg::COL_W];
	end

	// program sequencer; reset aborts with no repair of the row
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st  <= eedc_pkg::ST_IDLE;
			cnt <= '0;
		end else if (halt_req || sw_abort) begin
			st  <= eedc_pkg::ST_IDLE;
			cnt <= '0;
		end else begin
			unique case (st)
				eedc_pkg::ST_IDLE: begin
					cnt <= '0;
					if (start)
						st <= eedc_pkg::ST_ERASE;
				end
				eedc_pkg::ST_ERASE: begin
					cnt <= cnt + 16'h0001;
					if (erase_done) begin
						st  <= eedc_pkg::ST_WRITE;
						cnt <= '0;
					end
				end
				eedc_pkg::ST_WRITE: begin
					cnt <= cnt + 16'h0001;
					if (prog_done) begin
						st  <= eedc_pkg::ST_IDLE;
						cnt <= '0;
					end
				end
			endcase
		end
	end

	// array cells; cycle erase and write only touch latched columns of the row, reset and unprotect erase every cell
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < eedc_pkg::ARR_BYTES; i++)
				arr[i] <= eedc_pkg::ERASED;
		end else if (unprotect) begin
			for (int i = 0; i < eedc_pkg::ARR_BYTES; i++)
				arr[i] <= eedc_pkg::ERASED;
		end else if (!halt_req && !sw_abort && (erase_done || prog_done)) begin
			for (int i = 0; i < eedc_pkg::ROW_BYTES; i++)
				if (lat_if.valid[i])
					arr[{row, 5'(i)}] <= erase_done ? eedc_pkg::ERASED : lat_if.data[i];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prot       <= 1'b0;
			pmem_erase <= 1'b0;
		end else begin
			pmem_erase <= unprotect;
			if (opt_wr && wb_dat_i[eedc_pkg::PROT_BIT])
				prot <= 1'b1;
			else if (unprotect)
				prot <= 1'b0;
		end
	end

	// a running cycle is finished before wait is entered
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			eeprom_wait <= 1'b0;
			eeprom_halt <= 1'b0;
		end else begin
			eeprom_wait <= wfi_req && !halt_req && (!busy || prog_done);
			eeprom_halt <= halt_req;
		end
	end

	property p_done_clears;
		@(posedge ref_clk) disable iff (rst)
		prog_done && !halt_req && !sw_abort |=> !latch_mode && !busy && lat_if.valid == '0;
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("completion left bits set");

	property p_halt;
		@(posedge ref_clk) disable iff (rst)
		halt_req |=> !busy && !latch_mode && lat_if.valid == '0 && eeprom_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("halt did not abort");

	property p_lat_hold;
		@(posedge ref_clk) disable iff (rst)
		csr_wr && busy && !wb_dat_i[eedc_pkg::LAT_BIT] && !halt_req && !prog_done |=> latch_mode;
	endproperty
	a_lat_hold: assert property (p_lat_hold) else $error("latch mode cleared while programming");

	property p_start;
		@(posedge ref_clk) disable iff (rst)
		start |=> st == eedc_pkg::ST_ERASE && prog_busy;
	endproperty
	a_start: assert property (p_start) else $error("program start not taken");

	property p_back_to_back;
		@(posedge ref_clk) disable iff (rst)
		erase_done && !halt_req && !sw_abort |=> st == eedc_pkg::ST_WRITE && cnt == 16'h0000;
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("phases not chained");

	property p_abort;
		@(posedge ref_clk) disable iff (rst)
		sw_abort |=> !busy;
	endproperty
	a_abort: assert property (p_abort) else $error("software abort ignored");

	property p_undriven;
		@(posedge ref_clk) disable iff (rst)
		req && !wb_ack_o && !wb_we_i && arr_hit && latch_mode |=> !rd_driven && wb_dat_o == 32'h00000000;
	endproperty
	a_undriven: assert property (p_undriven) else $error("read in write mode drove data");

	property p_ignore_wr;
		@(posedge ref_clk) disable iff (rst)
		acc && wb_we_i && arr_hit && !latch_mode |=> lat_if.valid == $past(lat_if.valid);
	endproperty
	a_ignore_wr: assert property (p_ignore_wr) else $error("write latched in read mode");

	property p_reserved;
		@(posedge ref_clk) disable iff (rst)
		req && !wb_ack_o && !wb_we_i && csr_hit |=> wb_ack_o && wb_dat_o[7:2] == 6'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved csr bits nonzero");

	property p_wait;
		@(posedge ref_clk) disable iff (rst)
		wfi_req && !halt_req && !busy |=> eeprom_wait;
	endproperty
	a_wait: assert property (p_wait) else $error("idle wait not entered");

	// cycles spent busy, kept only so the cycle length can be checked
	logic [17:0] run_len;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			run_len <= '0;
		else if (busy)
			run_len <= run_len + 18'h00001;
		else
			run_len <= '0;
	end

	property p_cycle_len;
		@(posedge ref_clk) disable iff (rst)
		$fell(busy) && !$past(halt_req) && !$past(sw_abort) |-> run_len == RUN_LEN;
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("program cycle length wrong");

	property p_read_rom;
		@(posedge ref_clk) disable iff (rst)
		req && !wb_ack_o && !wb_we_i && arr_hit && !latch_mode && !blocked |=>
			rd_driven && wb_dat_o == {24'h000000, $past(arr[idx])};
	endproperty
	a_read_rom: assert property (p_read_rom) else $error("array read returned wrong byte");

	property p_row_capture;
		@(posedge ref_clk) disable iff (rst)
		arr_wr |=> row == $past(idx[6:eedc_pkg::COL_W]);
	endproperty
	a_row_capture: assert property (p_row_capture) else $error("program row not taken from last write");

	property p_commit;
		@(posedge ref_clk) disable iff (rst)
		prog_done && !halt_req && !sw_abort && lat_if.valid[0] |=>
			arr[{row, 5'h00}] == $past(lat_if.data[0]);
	endproperty
	a_commit: assert property (p_commit) else $error("latched byte not programmed");

	property p_protect_rd;
		@(posedge ref_clk) disable iff (rst)
		req && !wb_ack_o && !wb_we_i && arr_hit && !latch_mode && blocked |=> wb_dat_o == 32'h00000000;
	endproperty
	a_protect_rd: assert property (p_protect_rd) else $error("protected array read out");

	property p_protect_wr;
		@(posedge ref_clk) disable iff (rst)
		acc && wb_we_i && arr_hit && blocked && !lat_if.clr |=> lat_if.valid == $past(lat_if.valid);
	endproperty
	a_protect_wr: assert property (p_protect_wr) else $error("protected array write latched");

	property p_unprotect;
		@(posedge ref_clk) disable iff (rst)
		unprotect |=> pmem_erase && !prot && arr[$past(idx)] == eedc_pkg::ERASED;
	endproperty
	a_unprotect: assert property (p_unprotect) else $error("protection removal did not erase");

	property p_wait_hold;
		@(posedge ref_clk) disable iff (rst)
		wfi_req && !halt_req && busy && !prog_done |=> !eeprom_wait;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("wait entered during program cycle");

	property p_csr_read;
		@(posedge ref_clk) disable iff (rst)
		req && !wb_ack_o && !wb_we_i && csr_hit |=> wb_dat_o[1:0] == $past({latch_mode, busy});
	endproperty
	a_csr_read: assert property (p_csr_read) else $error("status bits read wrong");

	property p_lat_set;
		@(posedge ref_clk) disable iff (rst)
		csr_wr && wb_dat_i[eedc_pkg::LAT_BIT] && !halt_req && !prog_done |=> latch_mode;
	endproperty
	a_lat_set: assert property (p_lat_set) else $error("latch mode not set by software");
endmodule : eedc_top
`default_nettype wire
